// ===== dv/scmc_host_model.sv
// Remote host model that talks 8N1 to the controller's serial pins.
`timescale 1ns/1ps
`default_nettype none
module scmc_host_model #(
   parameter int unsigned BIT_CYC = 16
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_b;
   int         stop_err = 0;
   // The line idles high between frames, as an unloaded transmitter does.
   initial rxd_o = 1'b1;
   // One frame: start low, eight bits low first, stop high.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i);
         rxd_o <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk_i);
      end
   endtask
   // The caller hands in the whole text, braces included.
   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++) begin
         send_byte(s[i]);
      end
   endtask
   // Mid-bit sampling; a bad stop bit is counted so the bench can fail.
   initial begin
      forever begin
         @(posedge clk_i);
         if (rst_i === 1'b0 && txd_i === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CYC) @(posedge clk_i);
               rx_b[i] = txd_i;
            end
            repeat (BIT_CYC) @(posedge clk_i);
            if (txd_i !== 1'b1) begin
               stop_err++;
            end
            rx_q.push_back(rx_b);
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/scmc_top_tb_top.sv
// Self-checking bench for the serial command and menu controller.
`timescale 1ns/1ps
`default_nettype none
module scmc_top_tb_top;
   localparam int unsigned BIT = 16;
   localparam int unsigned TMO = 2000;
   logic                 clk;
   logic                 rst;
   logic [3:0]           adr;
   logic [31:0]          wdat;
   logic [31:0]          rdat;
   logic [3:0]           sel;
   logic                 we;
   logic                 cyc;
   logic                 stb;
   logic                 ack;
   logic                 rxd;
   logic                 txd;
   logic [2:0]           sw;
   logic [1:0]           pll;
   scmc_pkg::scmc_cfg_s  nv_in;
   scmc_pkg::scmc_cfg_s  nv_out;
   scmc_pkg::scmc_cfg_s  cfg;
   scmc_pkg::scmc_disp_e disp;
   logic                 nv_wr;
   logic                 nv_seen;
   logic                 alarm;
   logic [31:0]          r;
   int                   failures = 0;
   int                   compares = 0;
   int                   cycles = 0;
   scmc_top #(.TMO_CYC(TMO), .SPLASH_CYC(50), .BIT_CYC(BIT)) uut (
      .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd),
      .sw_menu_i(sw[0]), .sw_up_i(sw[1]), .sw_down_i(sw[2]),
      .pll_unlock_i(pll), .nv_cfg_i(nv_in), .nv_cfg_o(nv_out),
      .nv_wr_o(nv_wr), .cfg_o(cfg), .disp_o(disp), .alarm_o(alarm));
   scmc_host_model #(.BIT_CYC(BIT)) host (
      .clk_i(clk), .rst_i(rst), .txd_i(txd), .rxd_o(rxd));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Store strobes are latched so a one-cycle pulse is never missed.
   always @(posedge clk) begin
      cycles++;
      if (nv_wr === 1'b1) begin
         nv_seen <= 1'b1;
      end
      if (cycles == 60000) begin
         failures++;
         $display("ERROR %0t run did not finish in time", $time);
         wrap_up();
      end
   end
   // Compare, count and report at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic Wishbone cycle held until ack is sampled high.
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   // Switch levels pass a synchroniser, so each press is held a while.
   task automatic press(input int k);
      @(posedge clk);
      sw[k] <= 1'b1;
      repeat (6) @(posedge clk);
      sw[k] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   // Sends a message, checks the reply bytes and the live settings.
   task automatic cmd(input string s, input string rp, input logic [7:0] e);
      host.rx_q.delete();
      host.send_str(s);
      while (host.rx_q.size() < rp.len()) @(posedge clk);
      repeat (BIT * 12) @(posedge clk);
      chk(32'(host.rx_q.size()), 32'(rp.len()));
      for (int i = 0; i < rp.len(); i++) begin
         chk(32'(host.rx_q[i]), 32'(rp[i]));
      end
      chk(32'(cfg), 32'(e));
   endtask
   task automatic t_boot;
      repeat (20) @(posedge clk);
      chk(32'(disp), 32'(scmc_pkg::DSP_ALL));
      chk(32'(txd), 32'h0000_0001);
      repeat (50) @(posedge clk);
      chk(32'(disp), 32'(scmc_pkg::DSP_VER));
      repeat (60) @(posedge clk);
      chk(32'(disp), 32'(scmc_pkg::DSP_RUN));
      chk(32'(cfg), 32'({5'h03, 3'h0}));
      $display("boot sequence test done");
   endtask
   task automatic t_bus;
      wb(1'b0, scmc_pkg::REG_LEVEL, 32'h0000_0000);
      chk(r, 32'h0000_001E);
      wb(1'b0, 4'hC, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      wb(1'b1, scmc_pkg::REG_CTRL, 32'h0000_0027);
      wb(1'b0, scmc_pkg::REG_CTRL, 32'h0000_0000);
      chk(r, 32'h0000_0027);
      $display("register bus test done");
   endtask
   task automatic t_serial;
      cmd("{07C305}", ">", {5'h05, 3'h0});
      chk(32'(nv_out), 32'({5'h05, 3'h0}));
      cmd("{08C307}", "", {5'h05, 3'h0});
      cmd("{07S1}", "{07S1050}", {5'h05, 3'h0});
      wb(1'b1, scmc_pkg::REG_CTRL, 32'h0000_0000);
      cmd("{C321}", ">", {5'h05, 3'h0});
      cmd("{C51}", ">", {5'h05, 3'h4});
      cmd("{CE1}", ">", {5'h05, 3'h6});
      cmd("{C50}", ">", {5'h05, 3'h2});
      cmd("#", "", {5'h05, 3'h3});
      cmd("{CR0}", ">", {5'h05, 3'h2});
      cmd("{S1}", "{S1050}", {5'h05, 3'h2});
      wb(1'b1, scmc_pkg::REG_LEVEL, 32'h0000_000F);
      cmd("{C310}", ">", {5'h05, 3'h2});
      cmd("{C305}", ">", {5'h05, 3'h2});
      wb(1'b1, scmc_pkg::REG_LEVEL, 32'h0000_001E);
      cmd("{C306}", ">", {5'h06, 3'h2});
      $display("serial command test done");
   endtask
   task automatic t_menu;
      nv_seen = 1'b0;
      press(0);
      press(1);
      press(1);
      chk(32'(cfg), 32'({5'h08, 3'h2}));
      press(0);
      press(0);
      press(1);
      chk(32'(cfg), 32'({5'h08, 3'h0}));
      press(0);
      press(2);
      chk(32'(cfg), 32'({5'h08, 3'h4}));
      press(0);
      press(2);
      chk(32'(cfg), 32'({5'h06, 3'h2}));
      chk(32'(nv_seen), 32'h0000_0000);
      press(0);
      press(1);
      for (int i = 0; i < 4; i++) begin
         press(0);
      end
      press(1);
      chk(32'(nv_seen), 32'h0000_0001);
      chk(32'(nv_out), 32'({5'h07, 3'h2}));
      press(0);
      press(1);
      repeat (TMO + 200) @(posedge clk);
      chk(32'(cfg), 32'({5'h07, 3'h2}));
      $display("front panel menu test done");
   endtask
   task automatic t_alarm;
      pll <= 2'b10;
      repeat (6) @(posedge clk);
      chk(32'(alarm), 32'h0000_0001);
      pll <= 2'b00;
      repeat (6) @(posedge clk);
      chk(32'(alarm), 32'h0000_0000);
      pll <= 2'b01;
      repeat (6) @(posedge clk);
      chk(32'(alarm), 32'h0000_0001);
      $display("lock alarm test done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence: reset for twelve cycles, then each scenario in turn.
   initial begin
      rst = 1'b1;
      adr = 4'h0;
      wdat = 32'h0000_0000;
      sel = 4'hF;
      we = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      sw = 3'h0;
      pll = 2'h0;
      nv_seen = 1'b0;
      nv_in = {5'h03, 3'h0};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_boot();
      t_bus();
      t_serial();
      t_menu();
      t_alarm();
      chk(32'(host.stop_err), 32'h0000_0000);
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== shared/scmc_pkg.sv
// Shared constants and types for the serial command and menu controller.
package scmc_pkg;
   // Clock and serial timing.
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned BAUD          = 9600;
   localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
   localparam int unsigned MENU_TMO_S    = 12;
   localparam int unsigned MENU_TMO_CYC  = MENU_TMO_S * CLK_HZ;
   localparam int unsigned SPLASH_MS     = 500;
   localparam int unsigned SPLASH_CYC    = SPLASH_MS * (CLK_HZ / 1000);
   // Protocol characters.
   localparam logic [7:0] CH_OPEN   = 8'h7B;
   localparam logic [7:0] CH_CLOSE  = 8'h7D;
   localparam logic [7:0] CH_HASH   = 8'h23;
   localparam logic [7:0] CH_ACK    = 8'h3E;
   localparam logic [7:0] CH_CMD    = 8'h43;
   localparam logic [7:0] CH_STAT   = 8'h53;
   localparam logic [7:0] CH_ZERO   = 8'h30;
   localparam logic [7:0] ID_GAIN   = 8'h33;
   localparam logic [7:0] ID_INS    = 8'h35;
   localparam logic [7:0] ID_EXT    = 8'h45;
   localparam logic [7:0] ID_REM    = 8'h52;
   localparam logic [7:0] ID_QRY    = 8'h31;
   // Limits.
   localparam logic [4:0] GAIN_MAX  = 5'h14;
   localparam logic [4:0] ADDR_MAX  = 5'h1F;
   localparam logic [7:0] OUT_MIN   = 8'h1E; // -30 dBm as magnitude.
   localparam logic [7:0] OUT_MAX   = 8'h0A; // -10 dBm as magnitude.
   localparam int unsigned MSG_MAX  = 6;
   // Wishbone register map (word offsets are byte addresses).
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_STAT  = 4'h4;
   localparam logic [3:0] REG_LEVEL = 4'h8;
   // Settings carrier.
   typedef struct packed {
      logic [4:0] gain;
      logic       ins;
      logic       ext;
      logic       remote;
   } scmc_cfg_s;
   localparam scmc_cfg_s CFG_RST = '{gain: 5'h00, ins: 1'b0, ext: 1'b0,
                                     remote: 1'b0};
   typedef enum logic [1:0] {
      DSP_ALL = 2'b00, DSP_VER = 2'b01, DSP_RUN = 2'b11
   } scmc_disp_e;
   typedef enum logic [2:0] {
      MN_IDLE = 3'b000, MN_GAIN = 3'b001, MN_REM = 3'b011,
      MN_EXT  = 3'b010, MN_INS  = 3'b110, MN_SAVE = 3'b111
   } scmc_menu_e;
endpackage

// ===== verilog/scmc_top.sv
// Serial command interpreter and front-panel menu engine.
// Notes on behaviour
// - Messages framed by braces; only inside parsed.
// - First char after prefix is C or S.
// - Identifier char then command-specific data chars.
// - Two-digit address 00-31 only in multidrop.
// - Gain command takes two digits 00-20 dB.
// - Insertion command: zero disables, one enables.
// - External reference command: zero off, one on.
// - Link is 9600 baud, 8N1, both directions.
// - Menu session commits only on confirmed save.
// - Twelve idle seconds abandon session, restore settings.
// - Gain edits apply live, stored only on yes.
// - Save yes commits; no restores prior settings.
// - Committed settings kept in nonvolatile storage.
// - Power-up shows all segments, version, then run.
// - Alarm follows any PLL loss of lock.
// - Refuse gain giving output outside -10..-30 dBm.
// - Vertical switch toggles on/off items either way.
// - Executed command acknowledged with one greater-than.
// - Gain query returns framed id, gain, alarm.
`timescale 1ns/1ps
`default_nettype none
module scmc_top #(
   parameter int unsigned TMO_CYC    = scmc_pkg::MENU_TMO_CYC,
   parameter int unsigned SPLASH_CYC = scmc_pkg::SPLASH_CYC,
   parameter int unsigned BIT_CYC    = scmc_pkg::BIT_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [3:0]          wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic                wb_we_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                rxd_i,
   output logic                     txd_o,
   input  wire logic                sw_menu_i,
   input  wire logic                sw_up_i,
   input  wire logic                sw_down_i,
   input  wire logic [1:0]          pll_unlock_i,
   input  wire scmc_pkg::scmc_cfg_s nv_cfg_i,
   output scmc_pkg::scmc_cfg_s      nv_cfg_o,
   output logic                     nv_wr_o,
   output scmc_pkg::scmc_cfg_s      cfg_o,
   output scmc_pkg::scmc_disp_e     disp_o,
   output logic                     alarm_o
);
   // Bit counters are 16 bits wide; refuse timings that they cannot hold.
   if (BIT_CYC < 4 || BIT_CYC > 32'h0000_FFFF || TMO_CYC < 2 ||
       SPLASH_CYC < 2) begin : g_bad_timing
      $error("scmc_top: timing parameters out of range");
   end

   // Two-flop synchronisers on all pins from outside the clock domain.
   logic [5:0] s1_q, s2_q;
   always_ff @(posedge clk_i) begin
      s1_q <= {rxd_i, sw_menu_i, sw_up_i, sw_down_i, pll_unlock_i};
      s2_q <= s1_q;
   end
   logic rx_s, menu_s, up_s, dn_s, unl_s;
   assign rx_s  = s2_q[5];
   assign menu_s = s2_q[4];
   assign up_s  = s2_q[3];
   assign dn_s  = s2_q[2];
   assign unl_s = |s2_q[1:0];

   // Receiver: 8N1, sampled mid-bit; a framing error drops the byte.
   logic [15:0] rc_q, rc_d;
   logic [3:0]  rb_q, rb_d;
   logic [7:0]  rs_q, rs_d;
   logic        rbusy_q, rbusy_d, rv;
   always_comb begin
      rc_d = rc_q; rb_d = rb_q; rs_d = rs_q; rbusy_d = rbusy_q; rv = 1'b0;
      if (!rbusy_q) begin
         if (!rx_s) begin
            rbusy_d = 1'b1; rb_d = 4'h0; rc_d = 16'(BIT_CYC / 2);
         end
      end else if (rc_q == 16'h0000) begin
         rc_d = 16'(BIT_CYC - 1);
         rb_d = rb_q + 4'h1;
         if (rb_q == 4'h0 && rx_s) rbusy_d = 1'b0;
         else if (rb_q >= 4'h1 && rb_q <= 4'h8) rs_d = {rx_s, rs_q[7:1]};
         else if (rb_q == 4'h9) begin
            rbusy_d = 1'b0; rv = rx_s;
         end
      end else rc_d = rc_q - 16'h0001;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_q <= 16'h0000; rb_q <= 4'h0; rs_q <= 8'h00; rbusy_q <= 1'b0;
      end else begin
         rc_q <= rc_d; rb_q <= rb_d; rs_q <= rs_d; rbusy_q <= rbusy_d;
      end
   end

   // Register file: control (multidrop, address), status, input level.
   logic       md_q, md_d;
   logic [4:0] addr_q, addr_d;
   logic [7:0] lvl_q, lvl_d;
   logic       ack_q, ack_d;
   logic [31:0] rd_q, rd_d;
   scmc_pkg::scmc_cfg_s live_q, live_d, sav_q, sav_d;
   logic       alarm_q;
   scmc_pkg::scmc_disp_e disp_q, disp_d;
   scmc_pkg::scmc_menu_e mn_q, mn_d;
   always_comb begin
      md_d = md_q; addr_d = addr_q; lvl_d = lvl_q; rd_d = 32'h0000_0000;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      if (ack_d) begin
         unique case (wb_adr_i)
            scmc_pkg::REG_CTRL: rd_d = {26'h0, md_q, addr_q};
            scmc_pkg::REG_STAT: rd_d = {18'h0, mn_q, disp_q, alarm_q, live_q};
            scmc_pkg::REG_LEVEL: rd_d = {24'h0, lvl_q};
            default: rd_d = 32'h0000_0000;
         endcase
      end
      // A write lands at the edge where the master samples ack high.
      if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == scmc_pkg::REG_CTRL) begin
            md_d = wb_dat_i[5];
            addr_d = (wb_dat_i[4:0] > scmc_pkg::ADDR_MAX) ?
                     addr_q : wb_dat_i[4:0];
         end
         if (wb_adr_i == scmc_pkg::REG_LEVEL) lvl_d = wb_dat_i[7:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         md_q <= 1'b0; addr_q <= 5'h00; lvl_q <= scmc_pkg::OUT_MIN;
         ack_q <= 1'b0; rd_q <= 32'h0000_0000;
      end else begin
         md_q <= md_d; addr_q <= addr_d; lvl_q <= lvl_d;
         ack_q <= ack_d; rd_q <= rd_d;
      end
   end

   // Output = -level + gain; allowed when magnitude within 10..30.
   function automatic logic gain_ok(input logic [4:0] g, input logic [7:0] l);
      logic [8:0] m;
      m = {1'b0, l} - {4'h0, g};
      gain_ok = (g <= scmc_pkg::GAIN_MAX) && !m[8] &&
                (m[7:0] >= scmc_pkg::OUT_MAX) && (m[7:0] <= scmc_pkg::OUT_MIN);
   endfunction

   // Parser: collects bytes between braces, hash enters remote.
   logic [7:0] buf_q [scmc_pkg::MSG_MAX];
   logic [7:0] buf_d [scmc_pkg::MSG_MAX];
   logic [2:0] n_q, n_d;
   logic       in_q, in_d, ovf_q, ovf_d;
   logic       run_cmd, want_ack, want_rep, go_rem;
   logic [7:0] t0, t1, t2, t3, t4;
   logic [6:0] dig;
   always_comb begin
      for (int i = 0; i < scmc_pkg::MSG_MAX; i++) buf_d[i] = buf_q[i];
      n_d = n_q; in_d = in_q; ovf_d = ovf_q; run_cmd = 1'b0; go_rem = 1'b0;
      if (rv) begin
         if (rs_q == scmc_pkg::CH_OPEN) begin
            in_d = 1'b1; n_d = 3'h0; ovf_d = 1'b0;
         end else if (rs_q == scmc_pkg::CH_CLOSE && in_q) begin
            in_d = 1'b0; run_cmd = !ovf_q;
         end else if (in_q) begin
            if (n_q == 3'(scmc_pkg::MSG_MAX)) ovf_d = 1'b1;
            else begin
               buf_d[n_q] = rs_q; n_d = n_q + 3'h1;
            end
         end else if (rs_q == scmc_pkg::CH_HASH) go_rem = 1'b1;
      end
   end
   // Strip the unit address prefix in multidrop mode.
   always_comb begin
      t0 = md_q ? buf_q[2] : buf_q[0];
      t1 = md_q ? buf_q[3] : buf_q[1];
      t2 = md_q ? buf_q[4] : buf_q[2];
      t3 = md_q ? buf_q[5] : buf_q[3];
      t4 = {5'h00, md_q ? n_q - 3'h2 : n_q};
      // Seven bits hold any two decimal digits without wrapping.
      dig = 7'(buf_q[0][3:0]) * 7'h0A + 7'(buf_q[1][3:0]);
   end
   logic adr_ok, d2;
   assign adr_ok = !md_q || (n_q >= 3'h2 && dig == {2'b00, addr_q});
   assign d2 = (t2[7:4] == 4'h3) && (t3[7:4] == 4'h3) && (t2[3:0] <= 4'h9)
               && (t3[3:0] <= 4'h9);
   // Two digits reach 99, so the value is range checked at seven bits
   // before it is narrowed to the five-bit gain field.
   logic [6:0] cgw;
   logic [4:0] cg;
   assign cgw = 7'(t2[3:0]) * 7'h0A + 7'(t3[3:0]);
   assign cg  = cgw[4:0];
   logic bit1, bval;
   assign bit1 = (t4 == 8'h03) && (t2[7:1] == 7'h18);
   assign bval = t2[0];

   // Settings, menu, display and splash timer state.
   logic [31:0] tm_q, tm_d;
   logic [2:0]  pv_q, pv_d;
   logic        nvw_d, nvw_q;
   logic        up_e, dn_e, mn_e;
   assign mn_e = menu_s && !pv_q[2];
   assign up_e = up_s && !pv_q[1];
   assign dn_e = dn_s && !pv_q[0];
   always_comb begin
      live_d = live_q; sav_d = sav_q; mn_d = mn_q; disp_d = disp_q;
      tm_d = tm_q; nvw_d = 1'b0; want_ack = 1'b0; want_rep = 1'b0;
      pv_d = {menu_s, up_s, dn_s};
      if (go_rem) live_d.remote = 1'b1;
      if (run_cmd && adr_ok && t0 == scmc_pkg::CH_CMD) begin
         want_ack = 1'b1;
         unique case (t1)
            scmc_pkg::ID_GAIN:
               if (t4 == 8'h04 && d2 && cgw <= 7'(scmc_pkg::GAIN_MAX) &&
                   gain_ok(cg, lvl_q))
                  live_d.gain = cg;
            scmc_pkg::ID_INS: if (bit1) live_d.ins = bval;
            scmc_pkg::ID_EXT: if (bit1) live_d.ext = bval;
            scmc_pkg::ID_REM:
               if (bit1 && t2 == scmc_pkg::CH_ZERO) live_d.remote = 1'b0;
            default: want_ack = 1'b0;
         endcase
         if (want_ack && mn_q == scmc_pkg::MN_IDLE) begin
            sav_d = live_d; nvw_d = 1'b1;
         end
      end else if (run_cmd && adr_ok && t0 == scmc_pkg::CH_STAT &&
                   t1 == scmc_pkg::ID_QRY && t4 == 8'h02) begin
         want_rep = 1'b1;
      end
      if (disp_q != scmc_pkg::DSP_RUN) begin
         tm_d = tm_q + 32'h1;
         if (tm_q == 32'(SPLASH_CYC - 1)) begin
            tm_d = 32'h0;
            disp_d = (disp_q == scmc_pkg::DSP_ALL) ? scmc_pkg::DSP_VER
                                                   : scmc_pkg::DSP_RUN;
            if (disp_q == scmc_pkg::DSP_VER) begin
               live_d = nv_cfg_i; sav_d = nv_cfg_i;
            end
         end
      end else if (mn_q == scmc_pkg::MN_IDLE) begin
         tm_d = 32'h0;
         if (mn_e) mn_d = scmc_pkg::MN_GAIN;
      end else begin
         tm_d = (mn_e || up_e || dn_e) ? 32'h0 : tm_q + 32'h1;
         if (tm_q == 32'(TMO_CYC - 1)) begin
            live_d = sav_q; mn_d = scmc_pkg::MN_IDLE;
         end else begin
            unique case (mn_q)
               scmc_pkg::MN_GAIN: begin
                  if (up_e && gain_ok(live_q.gain + 5'h1, lvl_q))
                     live_d.gain = live_q.gain + 5'h1;
                  if (dn_e && gain_ok(live_q.gain - 5'h1, lvl_q) &&
                      live_q.gain != 5'h00)
                     live_d.gain = live_q.gain - 5'h1;
                  if (mn_e) mn_d = scmc_pkg::MN_REM;
               end
               scmc_pkg::MN_REM: begin
                  if (up_e || dn_e) live_d.remote = !live_q.remote;
                  if (mn_e) mn_d = scmc_pkg::MN_EXT;
               end
               scmc_pkg::MN_EXT: begin
                  if (up_e || dn_e) live_d.ext = !live_q.ext;
                  if (mn_e) mn_d = scmc_pkg::MN_INS;
               end
               scmc_pkg::MN_INS: begin
                  if (up_e || dn_e) live_d.ins = !live_q.ins;
                  if (mn_e) mn_d = scmc_pkg::MN_SAVE;
               end
               scmc_pkg::MN_SAVE: begin
                  if (up_e) begin  // Up answers yes.
                     sav_d = live_q; nvw_d = 1'b1; mn_d = scmc_pkg::MN_IDLE;
                  end else if (dn_e) begin  // Down answers no.
                     live_d = sav_q; mn_d = scmc_pkg::MN_IDLE;
                  end
               end
               default: mn_d = scmc_pkg::MN_IDLE;
            endcase
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < scmc_pkg::MSG_MAX; i++) buf_q[i] <= 8'h00;
         n_q <= 3'h0; in_q <= 1'b0; ovf_q <= 1'b0;
         live_q <= scmc_pkg::CFG_RST; sav_q <= scmc_pkg::CFG_RST;
         mn_q <= scmc_pkg::MN_IDLE; disp_q <= scmc_pkg::DSP_ALL;
         tm_q <= 32'h0; pv_q <= 3'h0; nvw_q <= 1'b0; alarm_q <= 1'b0;
      end else begin
         for (int i = 0; i < scmc_pkg::MSG_MAX; i++) buf_q[i] <= buf_d[i];
         n_q <= n_d; in_q <= in_d; ovf_q <= ovf_d;
         live_q <= live_d; sav_q <= sav_d; mn_q <= mn_d; disp_q <= disp_d;
         tm_q <= tm_d; pv_q <= pv_d; nvw_q <= nvw_d;
         alarm_q <= unl_s;
      end
   end

   // Transmitter: queue of reply bytes, sent 8N1. The queue holds the
   // longest reply, a status answer that echoes the unit address.
   localparam int unsigned TQ_N = scmc_pkg::MSG_MAX + 3;
   logic [7:0]  tq_q [TQ_N];
   logic [7:0]  tq_d [TQ_N];
   logic [3:0]  tn_q, tn_d;
   logic [3:0]  tb_q, tb_d;
   logic [15:0] tc_q, tc_d;
   logic [9:0]  sh_q, sh_d;
   logic        tx_q, tx_d;
   logic [71:0] rep;
   logic [7:0]  g_hi, g_lo, al_ch;
   always_comb begin
      for (int i = 0; i < TQ_N; i++) tq_d[i] = tq_q[i];
      tn_d = tn_q; tb_d = tb_q; tc_d = tc_q; sh_d = sh_q; tx_d = tx_q;
      g_hi  = {4'h3, 4'(live_q.gain / 5'hA)};
      g_lo  = {4'h3, 4'(live_q.gain % 5'hA)};
      al_ch = {7'h18, alarm_q};
      // The reply is framed like a request; multidrop echoes the address.
      rep = md_q ? {scmc_pkg::CH_OPEN, buf_q[0], buf_q[1], scmc_pkg::CH_STAT,
                    scmc_pkg::ID_QRY, g_hi, g_lo, al_ch, scmc_pkg::CH_CLOSE}
                 : {scmc_pkg::CH_OPEN, scmc_pkg::CH_STAT, scmc_pkg::ID_QRY,
                    g_hi, g_lo, al_ch, scmc_pkg::CH_CLOSE, 16'h0000};
      if (want_ack && tn_q == 4'h0 && tb_q == 4'h0) begin
         tq_d[0] = scmc_pkg::CH_ACK; tn_d = 4'h1;
      end else if (want_rep && tn_q == 4'h0 && tb_q == 4'h0) begin
         for (int i = 0; i < TQ_N; i++) begin
            tq_d[i] = rep[71 - 8*i -: 8];
         end
         tn_d = md_q ? 4'(TQ_N) : 4'(TQ_N - 2);
      end else if (tb_q == 4'h0 && tn_q != 4'h0) begin
         // Eleven steps: the last one holds the stop bit a full bit time.
         sh_d = {1'b1, tq_q[0], 1'b0}; tb_d = 4'hB; tc_d = 16'h0;
         for (int i = 0; i < TQ_N - 1; i++) tq_d[i] = tq_q[i+1];
         tn_d = tn_q - 4'h1;
      end else if (tb_q != 4'h0) begin
         if (tc_q == 16'h0) begin
            tx_d = sh_q[0]; sh_d = {1'b1, sh_q[9:1]};
            tc_d = 16'(BIT_CYC - 1); tb_d = tb_q - 4'h1;
         end else tc_d = tc_q - 16'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < TQ_N; i++) tq_q[i] <= 8'h00;
         tn_q <= 4'h0; tb_q <= 4'h0; tc_q <= 16'h0;
         sh_q <= 10'h3FF; tx_q <= 1'b1;
      end else begin
         for (int i = 0; i < TQ_N; i++) tq_q[i] <= tq_d[i];
         tn_q <= tn_d; tb_q <= tb_d; tc_q <= tc_d; sh_q <= sh_d; tx_q <= tx_d;
      end
   end

   // All outputs straight from flip-flops.
   assign wb_dat_o = rd_q;
   assign wb_ack_o = ack_q;
   assign txd_o    = tx_q;
   assign cfg_o    = live_q;
   assign nv_cfg_o = sav_q;
   assign nv_wr_o  = nvw_q;
   assign disp_o   = disp_q;
   assign alarm_o  = alarm_q;

   chk_alarm_follows: assert property (@(posedge clk_i)
      disable iff (rst_i) $rose(unl_s) |=> alarm_o)
      else $error("alarm did not follow pll unlock");
   chk_gain_range: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $changed(cfg_o.gain) && disp_o == scmc_pkg::DSP_RUN &&
      $past(disp_o) == scmc_pkg::DSP_RUN |-> cfg_o.gain <= scmc_pkg::GAIN_MAX)
      else $error("gain above limit");
   chk_tx_idle: assert property (@(posedge clk_i)
      disable iff (rst_i) tb_q == 4'h0 |-> txd_o)
      else $error("tx line not idle high");
   chk_nv_on_save: assert property (@(posedge clk_i)
      disable iff (rst_i)
      nv_wr_o |-> $past(mn_q) inside {scmc_pkg::MN_SAVE, scmc_pkg::MN_IDLE})
      else $error("nonvolatile write outside save");
   chk_menu_timeout: assert property (@(posedge clk_i)
      disable iff (rst_i)
      mn_q != scmc_pkg::MN_IDLE && tm_q == 32'(TMO_CYC - 1)
      |=> mn_q == scmc_pkg::MN_IDLE && cfg_o == $past(sav_q))
      else $error("menu timeout did not restore");
   chk_save_no: assert property (@(posedge clk_i)
      disable iff (rst_i)
      mn_q == scmc_pkg::MN_SAVE && !up_e && dn_e && tm_q != 32'(TMO_CYC - 1)
      |=> cfg_o == $past(sav_q) && !nv_wr_o)
      else $error("save no did not restore");
   chk_splash_order: assert property (@(posedge clk_i)
      disable iff (rst_i)
      disp_o == scmc_pkg::DSP_RUN |=> disp_o == scmc_pkg::DSP_RUN)
      else $error("display left run state");
   chk_ack_pulse: assert property (@(posedge clk_i)
      disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire
